// file: include/calendar_clock_pkg.sv
// Purpose: Shared constants and types for the calendar clock with alarm
// Assumes: 8-bit I/O register port, 20 MHz reference clock
// Notes: Addresses are the low byte of the I/O address
package calendar_clock_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_TICK_COUNT = 8'he0;
    localparam logic [7:0] ADDR_MINUTE = 8'he1;
    localparam logic [7:0] ADDR_HOUR = 8'he2;
    localparam logic [7:0] ADDR_WEEKDAY = 8'he3;
    localparam logic [7:0] ADDR_MONTH_DAY = 8'he4;
    localparam logic [7:0] ADDR_MONTH = 8'he5;
    localparam logic [7:0] ADDR_YEAR = 8'he6;
    localparam logic [7:0] ADDR_CENTURY = 8'he7;
    localparam logic [7:0] ADDR_ALM_SECOND = 8'he8;
    localparam logic [7:0] ADDR_ALM_MINUTE = 8'he9;
    localparam logic [7:0] ADDR_ALM_HOUR = 8'hea;
    localparam logic [7:0] ADDR_ALM_WEEKDAY = 8'heb;
    localparam logic [7:0] ADDR_ALM_CTRL = 8'hec;
    localparam logic [7:0] ADDR_CTRL = 8'hed;
    // Control register bit positions
    localparam int CTRL_ALARM_FLAG = 7;
    localparam int CTRL_INT_EN = 6;
    localparam int CTRL_BCD_EN = 5;
    localparam int CTRL_LINE_SRC = 4;
    localparam int CTRL_FREQ_50 = 3;
    localparam int CTRL_UNLOCK = 0;
    // Alarm enable bit positions in the alarm control register
    localparam int AEN_SECOND = 0;
    localparam int AEN_MINUTE = 1;
    localparam int AEN_HOUR = 2;
    localparam int AEN_WEEKDAY = 3;
    // Values after reset
    localparam logic [3:0] ALARM_EN_RESET = 4'h0;
    localparam logic [7:0] ALARM_VAL_RESET = 8'h00;
    // Source edges per second
    localparam int XTAL_HZ = 32768;
    localparam int LINE_50_HZ = 50;
    localparam int LINE_60_HZ = 60;
    localparam logic [15:0] XTAL_EDGES = 16'(XTAL_HZ);
    localparam logic [15:0] LINE_50_EDGES = 16'(LINE_50_HZ);
    localparam logic [15:0] LINE_60_EDGES = 16'(LINE_60_HZ);
    // Field limits in binary
    localparam logic [6:0] SECOND_MAX = 7'd59;
    localparam logic [6:0] MINUTE_MAX = 7'd59;
    localparam logic [6:0] HOUR_MAX = 7'd23;
    localparam logic [6:0] WEEKDAY_MIN = 7'd1;
    localparam logic [6:0] WEEKDAY_MAX = 7'd7;
    localparam logic [6:0] MONTH_MAX = 7'd12;
    localparam logic [6:0] YEAR_MAX = 7'd99;

    // Register access request from the processor I/O cycle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } io_req_t;
endpackage

// file: verilog/calendar_clock.sv
// Purpose: Battery-backed calendar clock with one-second alarm compare
// Assumes: Crystal and mains clocks arrive on pins, async to i_ref_clk
// Notes: Count registers have no reset so they survive a system reset
// How it works
// - Separate seconds, minutes, hours, weekday, month day, year, century; 24-hour.
// - Every count and alarm register uses binary or decimal, by one select bit.
// - Month day kept correct; leap years handled only in decimal encoding.
// - Alarm set points for seconds, minutes, hours, weekday, each with own enable.
// - Alarm raised only when every enabled alarm equals its count; others ignored.
// - Alarm sets the flag; interrupt asserted only when interrupt enable is 1.
// - Reading the control register clears the flag and drops the interrupt.
// - Alarm value and alarm control registers are writable regardless of lock.
// - Alarm compare runs each time the count advances, once per second.
// - Writing unlock as 0 forces a compare, even if it was already 0.
// - Count source is the 32 kHz crystal or an external 50/60 Hz clock.
// - Control register selects clock source and 50 or 60 Hz line rate.
// - Any control register write clears the one-second prescaler.
// - After power-up reset all alarms are disabled; counts undefined.
// - Unlock stops counting and clears prescaler; lock restarts it from zero.
// - Unlocked: counting stops, counts writable. Locked: counting runs, writes ignored.
// - System reset leaves the clock locked, counting and read-only.
// - System reset leaves the seconds count unchanged.
// - Decimal seconds: tens 0-5 in [7:4], ones 0-9 in [3:0].
// - Binary seconds: one 8-bit value 00h-3Bh.
// - Hours: binary 00h-17h; decimal tens 0-2, ones 0-9.
// - Weekday counts 1 to 7 in low nibble; upper nibble reads zero.
`timescale 1ns/1ps
module calendar_clock (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Processor I/O cycle
    input wire calendar_clock_pkg::io_req_t i_io,
    output logic [7:0] o_io_rdata,
    // Count sources from pins
    input wire logic i_xtal_clk,
    input wire logic i_line_clk,
    // Interrupt to processor
    output logic o_alarm_irq
);
    // Binary to selected encoding
    function automatic logic [7:0] enc(input logic [6:0] b, input logic bcd);
        enc = bcd ? {4'(b / 7'd10), 4'(b % 7'd10)} : {1'b0, b};
    endfunction

    // Selected encoding to binary
    function automatic logic [6:0] dec(input logic [7:0] v, input logic bcd);
        dec = bcd ? 7'({3'b0, v[7:4]} * 7'd10 + {3'b0, v[3:0]}) : v[6:0];
    endfunction

    // Wrap or advance one field in the selected encoding
    function automatic logic [7:0] step(input logic [7:0] v, input logic [6:0] max,
                                       input logic [6:0] min, input logic bcd);
        if (v == enc(max, bcd)) begin
            step = enc(min, bcd);
        end else if (bcd && v[3:0] == 4'h9) begin
            step = {4'(v[7:4] + 4'h1), 4'h0};
        end else begin
            step = 8'(v + 8'h01);
        end
    endfunction

    // Control and alarm state
    logic unlock_q, int_en_q, bcd_q, line_src_q, freq_50_q, alarm_flag_q;
    logic [3:0] alarm_en_q;
    logic [7:0] alm_second_q, alm_minute_q, alm_hour_q, alm_weekday_q;
    // Count registers, no reset
    logic [7:0] tick_count_register, minute_q, hour_count_register, weekday_count_register;
    logic [7:0] month_day_q, month_q, year_q, century_q;
    logic [7:0] second_d, minute_d, hour_d, weekday_d, month_day_d, month_d, year_d;
    logic [7:0] century_d;
    logic c_min, c_hour, c_day, c_month, c_year, c_cent;
    // Source synchronisers and prescaler
    logic xtal_s1_q, xtal_s2_q, xtal_s3_q, line_s1_q, line_s2_q, line_s3_q;
    logic src_edge;
    logic [15:0] presc_q, presc_limit;
    logic tick, compare_q, alarm_match;
    logic ctrl_wr, ctrl_rd, count_wr;
    logic [6:0] dim;

    assign ctrl_wr = i_io.wr && i_io.addr == calendar_clock_pkg::ADDR_CTRL;
    assign ctrl_rd = i_io.rd && i_io.addr == calendar_clock_pkg::ADDR_CTRL;
    assign count_wr = i_io.wr && unlock_q;

    // Two-flop sync per pin, third flop only for edge detect
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            xtal_s1_q <= 1'b0;
            xtal_s2_q <= 1'b0;
            xtal_s3_q <= 1'b0;
            line_s1_q <= 1'b0;
            line_s2_q <= 1'b0;
            line_s3_q <= 1'b0;
        end else begin
            xtal_s1_q <= i_xtal_clk;
            xtal_s2_q <= xtal_s1_q;
            xtal_s3_q <= xtal_s2_q;
            line_s1_q <= i_line_clk;
            line_s2_q <= line_s1_q;
            line_s3_q <= line_s2_q;
        end
    end

    // Rising edge of the selected source
    assign src_edge = line_src_q ? (line_s2_q && !line_s3_q)
                                 : (xtal_s2_q && !xtal_s3_q);
    assign presc_limit = !line_src_q ? calendar_clock_pkg::XTAL_EDGES
                       : freq_50_q ? calendar_clock_pkg::LINE_50_EDGES
                       : calendar_clock_pkg::LINE_60_EDGES;
    assign tick = src_edge && presc_q == 16'(presc_limit - 16'h0001)
                  && !unlock_q && !ctrl_wr;

    // Prescaler; held clear while unlocked, so locking restarts from zero
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            presc_q <= 16'h0000;
        end else if (ctrl_wr || unlock_q) begin
            presc_q <= 16'h0000;
        end else if (src_edge) begin
            presc_q <= tick ? 16'h0000 : 16'(presc_q + 16'h0001);
        end
    end

    // Control register; reset leaves the clock locked
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            unlock_q <= 1'b0;
            int_en_q <= 1'b0;
            bcd_q <= 1'b0;
            line_src_q <= 1'b0;
            freq_50_q <= 1'b0;
        end else if (ctrl_wr) begin
            unlock_q <= i_io.wdata[calendar_clock_pkg::CTRL_UNLOCK];
            int_en_q <= i_io.wdata[calendar_clock_pkg::CTRL_INT_EN];
            bcd_q <= i_io.wdata[calendar_clock_pkg::CTRL_BCD_EN];
            line_src_q <= i_io.wdata[calendar_clock_pkg::CTRL_LINE_SRC];
            freq_50_q <= i_io.wdata[calendar_clock_pkg::CTRL_FREQ_50];
        end
    end

    // Alarm registers, writable whatever the lock state
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            alarm_en_q <= calendar_clock_pkg::ALARM_EN_RESET;
            alm_second_q <= calendar_clock_pkg::ALARM_VAL_RESET;
            alm_minute_q <= calendar_clock_pkg::ALARM_VAL_RESET;
            alm_hour_q <= calendar_clock_pkg::ALARM_VAL_RESET;
            alm_weekday_q <= calendar_clock_pkg::ALARM_VAL_RESET;
        end else if (i_io.wr) begin
            unique case (i_io.addr)
                calendar_clock_pkg::ADDR_ALM_SECOND: alm_second_q <= i_io.wdata;
                calendar_clock_pkg::ADDR_ALM_MINUTE: alm_minute_q <= i_io.wdata;
                calendar_clock_pkg::ADDR_ALM_HOUR: alm_hour_q <= i_io.wdata;
                calendar_clock_pkg::ADDR_ALM_WEEKDAY: alm_weekday_q <= {4'h0, i_io.wdata[3:0]};
                calendar_clock_pkg::ADDR_ALM_CTRL: alarm_en_q <= i_io.wdata[3:0];
                default: ;
            endcase
        end
    end

    // Days in current month; February gains a day only in decimal mode
    always_comb begin
        unique case (dec(month_q, bcd_q))
            7'd4, 7'd6, 7'd9, 7'd11: dim = 7'd30;
            7'd2: dim = (bcd_q && dec(year_q, bcd_q) % 7'd4 == 7'd0
                        && (year_q != 8'h00 || dec(century_q, bcd_q) % 7'd4 == 7'd0))
                        ? 7'd29 : 7'd28;
            default: dim = 7'd31;
        endcase
    end

    // Carry chain from seconds to century
    always_comb begin
        c_min = tick && tick_count_register == enc(calendar_clock_pkg::SECOND_MAX, bcd_q);
        c_hour = c_min && minute_q == enc(calendar_clock_pkg::MINUTE_MAX, bcd_q);
        c_day = c_hour && hour_count_register == enc(calendar_clock_pkg::HOUR_MAX, bcd_q);
        c_month = c_day && month_day_q == enc(dim, bcd_q);
        c_year = c_month && month_q == enc(calendar_clock_pkg::MONTH_MAX, bcd_q);
        c_cent = c_year && year_q == enc(calendar_clock_pkg::YEAR_MAX, bcd_q);
        second_d = step(tick_count_register, calendar_clock_pkg::SECOND_MAX, 7'd0, bcd_q);
        minute_d = step(minute_q, calendar_clock_pkg::MINUTE_MAX, 7'd0, bcd_q);
        hour_d = step(hour_count_register, calendar_clock_pkg::HOUR_MAX, 7'd0, bcd_q);
        weekday_d = step(weekday_count_register, calendar_clock_pkg::WEEKDAY_MAX,
                         calendar_clock_pkg::WEEKDAY_MIN, bcd_q);
        month_day_d = step(month_day_q, dim, 7'd1, bcd_q);
        month_d = step(month_q, calendar_clock_pkg::MONTH_MAX, 7'd1, bcd_q);
        year_d = step(year_q, calendar_clock_pkg::YEAR_MAX, 7'd0, bcd_q);
        century_d = step(century_q, calendar_clock_pkg::YEAR_MAX, 7'd0, bcd_q);
    end

    // Count registers: no reset so a system reset leaves them alone
    always_ff @(posedge i_ref_clk) begin
        if (count_wr && i_io.addr == calendar_clock_pkg::ADDR_TICK_COUNT) begin
            tick_count_register <= i_io.wdata;
        end else if (tick) begin
            tick_count_register <= second_d;
        end
        if (count_wr && i_io.addr == calendar_clock_pkg::ADDR_MINUTE) begin
            minute_q <= i_io.wdata;
        end else if (c_min) begin
            minute_q <= minute_d;
        end
        if (count_wr && i_io.addr == calendar_clock_pkg::ADDR_HOUR) begin
            hour_count_register <= i_io.wdata;
        end else if (c_hour) begin
            hour_count_register <= hour_d;
        end
        if (count_wr && i_io.addr == calendar_clock_pkg::ADDR_WEEKDAY) begin
            weekday_count_register <= {4'h0, i_io.wdata[3:0]};
        end else if (c_day) begin
            weekday_count_register <= weekday_d;
        end
        if (count_wr && i_io.addr == calendar_clock_pkg::ADDR_MONTH_DAY) begin
            month_day_q <= i_io.wdata;
        end else if (c_day) begin
            month_day_q <= month_day_d;
        end
        if (count_wr && i_io.addr == calendar_clock_pkg::ADDR_MONTH) begin
            month_q <= i_io.wdata;
        end else if (c_month) begin
            month_q <= month_d;
        end
        if (count_wr && i_io.addr == calendar_clock_pkg::ADDR_YEAR) begin
            year_q <= i_io.wdata;
        end else if (c_year) begin
            year_q <= year_d;
        end
        if (count_wr && i_io.addr == calendar_clock_pkg::ADDR_CENTURY) begin
            century_q <= i_io.wdata;
        end else if (c_cent) begin
            century_q <= century_d;
        end
    end

    // Compare one cycle after the count moves, so the new count is seen
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            compare_q <= 1'b0;
        end else begin
            compare_q <= tick
                || (ctrl_wr && !i_io.wdata[calendar_clock_pkg::CTRL_UNLOCK]);
        end
    end

    // Enabled fields must all match; with none enabled nothing fires
    assign alarm_match = (alarm_en_q != 4'h0)
        && (!alarm_en_q[calendar_clock_pkg::AEN_SECOND] || alm_second_q == tick_count_register)
        && (!alarm_en_q[calendar_clock_pkg::AEN_MINUTE] || alm_minute_q == minute_q)
        && (!alarm_en_q[calendar_clock_pkg::AEN_HOUR] || alm_hour_q == hour_count_register)
        && (!alarm_en_q[calendar_clock_pkg::AEN_WEEKDAY]
            || alm_weekday_q == weekday_count_register);

    // Alarm flag: a set in the clearing cycle wins
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            alarm_flag_q <= 1'b0;
        end else if (compare_q && alarm_match) begin
            alarm_flag_q <= 1'b1;
        end else if (ctrl_rd) begin
            alarm_flag_q <= 1'b0;
        end
    end

    assign o_alarm_irq = alarm_flag_q && int_en_q;

    // Read data captured on the read strobe
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_io_rdata <= 8'h00;
        end else if (i_io.rd) begin
            unique case (i_io.addr)
                calendar_clock_pkg::ADDR_TICK_COUNT: o_io_rdata <= tick_count_register;
                calendar_clock_pkg::ADDR_MINUTE: o_io_rdata <= minute_q;
                calendar_clock_pkg::ADDR_HOUR: o_io_rdata <= hour_count_register;
                calendar_clock_pkg::ADDR_WEEKDAY: o_io_rdata <= weekday_count_register;
                calendar_clock_pkg::ADDR_MONTH_DAY: o_io_rdata <= month_day_q;
                calendar_clock_pkg::ADDR_MONTH: o_io_rdata <= month_q;
                calendar_clock_pkg::ADDR_YEAR: o_io_rdata <= year_q;
                calendar_clock_pkg::ADDR_CENTURY: o_io_rdata <= century_q;
                calendar_clock_pkg::ADDR_ALM_SECOND: o_io_rdata <= alm_second_q;
                calendar_clock_pkg::ADDR_ALM_MINUTE: o_io_rdata <= alm_minute_q;
                calendar_clock_pkg::ADDR_ALM_HOUR: o_io_rdata <= alm_hour_q;
                calendar_clock_pkg::ADDR_ALM_WEEKDAY: o_io_rdata <= alm_weekday_q;
                calendar_clock_pkg::ADDR_ALM_CTRL: o_io_rdata <= {4'h0, alarm_en_q};
                calendar_clock_pkg::ADDR_CTRL: o_io_rdata <= {alarm_flag_q, int_en_q, bcd_q,
                    line_src_q, freq_50_q, 2'b00, unlock_q};
                default: o_io_rdata <= 8'h00; // Unmapped reads zero
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    a_locked_no_write: assert property (
        i_io.wr && !unlock_q && !tick && i_io.addr == calendar_clock_pkg::ADDR_TICK_COUNT
        |=> $stable(tick_count_register))
        else $error("seconds changed by a locked write");
    a_unlock_halts: assert property (unlock_q |-> !tick [*1] ##1 (unlock_q || !tick))
        else $error("tick while unlocked");
    a_ctrl_clears_presc: assert property (ctrl_wr |=> presc_q == 16'h0000)
        else $error("prescaler not cleared by control write");
    a_second_wrap: assert property (
        tick && tick_count_register == enc(calendar_clock_pkg::SECOND_MAX, bcd_q)
        && !$changed(bcd_q) |=> tick_count_register == 8'h00)
        else $error("seconds did not wrap to zero");
    a_weekday_wrap: assert property (
        c_day && weekday_count_register == enc(calendar_clock_pkg::WEEKDAY_MAX, bcd_q)
        |=> weekday_count_register == 8'h01)
        else $error("weekday did not wrap to one");
    a_force_compare: assert property (
        ctrl_wr && !i_io.wdata[calendar_clock_pkg::CTRL_UNLOCK] |=> compare_q)
        else $error("unlock clear did not force compare");
    a_alarm_sets: assert property (
        compare_q && alarm_match |=> alarm_flag_q ##0 (o_alarm_irq == int_en_q))
        else $error("alarm flag or interrupt wrong after match");
    a_read_clears: assert property (
        ctrl_rd && !(compare_q && alarm_match) |=> !alarm_flag_q && !o_alarm_irq)
        else $error("control read did not clear alarm");
    a_tick_rate: assert property (
        tick |=> !tick [*2])
        else $error("ticks too close together");
    a_reset_locked: assert property (
        $rose(i_rst_b) |-> !unlock_q && alarm_en_q == 4'h0)
        else $error("reset state not locked with alarms off");
    a_hour_wrap: assert property (c_day |=> hour_count_register == 8'h00)
        else $error("hours did not wrap to zero");
    a_weekday_upper: assert property (c_day |=> weekday_count_register[7:4] == 4'h0)
        else $error("weekday upper nibble not zero");
    a_binary_february: assert property (
        c_day && !bcd_q && month_q == 8'h02 && month_day_q == 8'h1c
        |=> month_day_q == 8'h01)
        else $error("binary February passed day 28");

    c_alarm_irq: cover property (compare_q && alarm_match && int_en_q);
    c_minute_carry: cover property (c_min);
    c_century_carry: cover property (c_cent);
    c_forced_compare: cover property (ctrl_wr && !i_io.wdata[calendar_clock_pkg::CTRL_UNLOCK]
                                      && alarm_match);
endmodule // calendar_clock

// file: verification/mains_clock_source.sv
// Purpose: Crystal and mains pin model for the calendar clock
// Assumes: Sources sped up, rising edges well over 3 reference cycles apart
// Notes: Both run free, as a real oscillator and power line do
`timescale 1ns/1ps
module mains_clock_source #(
    parameter int LINE_HALF_NS = 200,
    parameter int XTAL_HALF_NS = 150
) (
    // Pin levels
    output logic o_xtal_clk,
    output logic o_line_clk
);
    // Free-running squares, phase unrelated to the reference clock
    initial begin
        o_xtal_clk = 1'b0;
        forever #(XTAL_HALF_NS) o_xtal_clk = ~o_xtal_clk;
    end
    // Offset start so line edges never sit on a reference edge
    initial begin
        o_line_clk = 1'b0;
        #13;
        forever #(LINE_HALF_NS) o_line_clk = ~o_line_clk;
    end
endmodule // mains_clock_source

// file: verification/calendar_clock_tb.sv
// Purpose: Self-checking bench for the calendar clock
// Assumes: Fast line source, 60 edges per tick take 480 reference cycles
// Notes: Addresses written as literals, ed is control, ec alarm enables
`timescale 1ns/1ps
module calendar_clock_tb;
    typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_t;
    logic i_ref_clk = 1'b0;
    logic i_rst_b = 1'b0;
    calendar_clock_pkg::io_req_t i_io = '0;
    logic [7:0] o_io_rdata;
    logic o_alarm_irq;
    logic xtal_clk;
    logic line_clk;
    logic [7:0] rv;
    logic [7:0] keep;
    int fails = 0;
    int n_tests = 0;
    // Locked writes: alarm side accepts, weekday alarm masks, unmapped reads zero
    row_t rows [6] = '{'{8'he8, 8'h15, 8'h15}, '{8'he9, 8'h2a, 8'h2a},
        '{8'hea, 8'h09, 8'h09}, '{8'heb, 8'hf5, 8'h05}, '{8'hec, 8'h0f, 8'h0f},
        '{8'hf0, 8'h5a, 8'h00}};

    // 20 MHz reference
    always #25 i_ref_clk = ~i_ref_clk;

    calendar_clock dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_io(i_io),
        .o_io_rdata(o_io_rdata), .i_xtal_clk(xtal_clk), .i_line_clk(line_clk),
        .o_alarm_irq(o_alarm_irq));
    mains_clock_source src (.o_xtal_clk(xtal_clk), .o_line_clk(line_clk));

    // Compare and count
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One-cycle write strobe, a free cycle after it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_io <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge i_ref_clk);
        i_io.wr <= 1'b0;
    endtask
    // Data is loaded at the edge where the strobe is high
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        i_io <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge i_ref_clk);
        i_io.rd <= 1'b0;
        #1 d = o_io_rdata;
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        rd(a, rv);
        chk(what, rv, exp);
    endtask
    task automatic finish_test();
        $display("TB: %0d checks, %0d mismatches", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Poll seconds under a bound; a tick is 480 cycles at most
    task automatic wait_sec(input logic [7:0] exp);
        for (int k = 0; k < 400; k++) begin
            rd(8'he0, rv);
            if (rv === exp) return;
        end
        fails++;
        $display("ERROR seconds timeout expected %h seen %h", exp, rv);
        finish_test();
    endtask
    // Unlock, load the last second of a day, lock, then wait for the rollover
    task automatic day_end(input logic [7:0] ctl, input logic [7:0] s, input logic [7:0] h,
                           input logic [7:0] md, input logic [7:0] mo, input logic [7:0] yr);
        wr(8'hed, ctl | 8'h01);
        wr(8'he0, s);
        wr(8'he1, s);
        wr(8'he2, h);
        wr(8'he4, md);
        wr(8'he5, mo);
        wr(8'he6, yr);
        wr(8'he7, 8'h20);
        wr(8'hed, ctl);
        wait_sec(8'h00);
    endtask

    initial begin
        repeat (2) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rdchk("alarm reg", rows[i].addr, rows[i].exp);
        end
        wr(8'hec, 8'h00);
        $display("test table done");
        // Binary wrap at 59 s, 59 min, 23 h, weekday 7
        wr(8'hed, 8'h11);
        wr(8'he0, 8'h3b);
        wr(8'he1, 8'h3b);
        wr(8'he2, 8'h17);
        wr(8'he3, 8'h07);
        wr(8'hed, 8'h10);
        wait_sec(8'h00);
        rdchk("minute", 8'he1, 8'h00);
        rdchk("hour", 8'he2, 8'h00);
        rdchk("weekday", 8'he3, 8'h01);
        wr(8'he0, 8'h2a);
        rdchk("locked seconds", 8'he0, 8'h00);
        $display("test binary wrap done");
        // Decimal wrap, and no counting while unlocked
        wr(8'hed, 8'h31);
        wr(8'he0, 8'h59);
        wr(8'he1, 8'h12);
        repeat (600) @(posedge i_ref_clk);
        rdchk("held seconds", 8'he0, 8'h59);
        wr(8'hed, 8'h30);
        wait_sec(8'h00);
        rdchk("minute bcd", 8'he1, 8'h13);
        $display("test decimal wrap done");
        // Calendar rollover: decimal leap day, year and century carry, binary February
        day_end(8'h30, 8'h59, 8'h23, 8'h28, 8'h02, 8'h12);
        rdchk("leap day", 8'he4, 8'h29);
        rdchk("hour bcd", 8'he2, 8'h00);
        day_end(8'h30, 8'h59, 8'h23, 8'h31, 8'h12, 8'h99);
        rdchk("new month day", 8'he4, 8'h01);
        rdchk("new month", 8'he5, 8'h01);
        rdchk("new year", 8'he6, 8'h00);
        rdchk("century", 8'he7, 8'h21);
        day_end(8'h10, 8'h3b, 8'h17, 8'h1c, 8'h02, 8'h0c);
        rdchk("no leap", 8'he4, 8'h01);
        rdchk("march", 8'he5, 8'h03);
        $display("test calendar done");
        // Tick-driven alarm on seconds, 50 Hz, interrupt enabled
        wr(8'hed, 8'h11);
        wr(8'he0, 8'h05);
        wr(8'he8, 8'h06);
        wr(8'hec, 8'h01);
        wr(8'hed, 8'h58);
        wait_sec(8'h06);
        repeat (3) @(posedge i_ref_clk);
        chk("irq", {7'h00, o_alarm_irq}, 8'h01);
        rdchk("ctrl flag", 8'hed, 8'hd8);
        chk("irq clr", {7'h00, o_alarm_irq}, 8'h00);
        rdchk("ctrl clr", 8'hed, 8'h58);
        $display("test tick alarm done");
        // Forced compare by rewriting unlock as 0, minutes only enabled
        wr(8'hec, 8'h00);
        wr(8'hed, 8'h11);
        wr(8'he1, 8'h2a);
        wr(8'hed, 8'h10);
        wr(8'he9, 8'h2a);
        wr(8'hec, 8'h02);
        rdchk("no compare", 8'hed, 8'h10);
        wr(8'hed, 8'h10);
        chk("irq off", {7'h00, o_alarm_irq}, 8'h00);
        rdchk("forced", 8'hed, 8'h90);
        $display("test forced compare done");
        // Reset keeps counts, locks, disables alarms
        rd(8'he0, keep);
        @(posedge i_ref_clk);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        chk("irq rst", {7'h00, o_alarm_irq}, 8'h00);
        i_rst_b <= 1'b1;
        rdchk("seconds kept", 8'he0, keep);
        rdchk("alarm en", 8'hec, 8'h00);
        rdchk("ctrl rst", 8'hed, 8'h00);
        wr(8'he0, keep ^ 8'h01);
        rdchk("seconds ro", 8'he0, keep);
        $display("test reset done");
        finish_test();
    end
endmodule // calendar_clock_tb
